// ==== verilog/aorc_pkg.sv ====
// Constants and types for the operand registers and arithmetic control block.
package aorc_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int MINOR_NS = 5000;
	localparam int MINOR_CYC = (MINOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TP_COUNT = 30;
	localparam int TP_SPACING = MINOR_CYC / TP_COUNT;
	localparam int CYC_W = 7;
	localparam int TP_W = 5;
	localparam int DATA_W = 20;
	localparam int WORD_W = 21;
	localparam int OPB_W = 22;
	localparam int PAR_BIT = 21;
	localparam int LOOP_N = 5;
	localparam int LOOP_SLOTS = 25;
	localparam int TMR_W = 14;
	localparam int ADDR_W = 12;
	localparam int ORDER_W = 5;
	localparam int DISP_N = 10;
	localparam int PASS_W = 5;
	localparam logic [PASS_W-1:0] DIV_PASSES = 5'h15;
	localparam logic [PASS_W-1:0] QLSB_PASS = 5'h14;
	localparam logic PAR_ODD = 1'h1;
	localparam logic [TP_W-1:0] TP_CLEAR = 5'h00;
	localparam logic [TP_W-1:0] TP_GATE = 5'h01;
	localparam logic [TMR_W-1:0] TMR_RESET = 14'h0000;
	localparam logic [OPB_W-1:0] OPB_RESET = 22'h000000;
	// Order-type encodings.
	localparam logic [ORDER_W-1:0] OP_NOP = 5'h00;
	localparam logic [ORDER_W-1:0] OP_ADD = 5'h01;
	localparam logic [ORDER_W-1:0] OP_SUB = 5'h02;
	localparam logic [ORDER_W-1:0] OP_MUL = 5'h03;
	localparam logic [ORDER_W-1:0] OP_DIV = 5'h04;
	localparam logic [ORDER_W-1:0] OP_MAD = 5'h05;
	localparam logic [ORDER_W-1:0] OP_SHIFT_LEFT_ADD_LOOPREG_INSTR = 5'h06;
	localparam logic [ORDER_W-1:0] OP_SHIFT_RIGHT_ADD_LOOPREG_INSTR = 5'h07;
	localparam logic [ORDER_W-1:0] OP_STORE = 5'h08;
	localparam logic [ORDER_W-1:0] OP_MULTIPLEXED_ANALOG_OUTPUT_INSTR = 5'h09;
	localparam logic [ORDER_W-1:0] OP_LOAD_TMR = 5'h0a;
	localparam logic [ORDER_W-1:0] OP_SENSE_TMR = 5'h0b;
	localparam logic [ORDER_W-1:0] OP_MEM_TEST = 5'h0c;
	localparam logic [ORDER_W-1:0] OP_LOOP_STORE = 5'h0d;
	typedef enum {ST_IDLE, ST_WAIT, ST_RUN} aorc_state_t;
endpackage

// ==== verilog/aorc_minor_gen.sv ====
// Minor-cycle divider and timing-pulse generator.
`timescale 1ns/10ps
module aorc_minor_gen (
	input wire logic core_clk,
	input wire logic rst_b,
	output logic minor_tick,
	output logic tp_tick,
	output logic [aorc_pkg::TP_W-1:0] tp_idx
);
	logic [aorc_pkg::CYC_W-1:0] cyc_ff;
	logic [aorc_pkg::TP_W-1:0] tp_ff;
	localparam logic [aorc_pkg::CYC_W-1:0] CYC_LAST = aorc_pkg::CYC_W'(aorc_pkg::MINOR_CYC - 1);
	localparam logic [aorc_pkg::CYC_W-1:0] TP_END =
		aorc_pkg::CYC_W'(aorc_pkg::TP_COUNT * aorc_pkg::TP_SPACING);
	localparam logic [aorc_pkg::CYC_W-1:0] TP_SP = aorc_pkg::CYC_W'(aorc_pkg::TP_SPACING);
	localparam logic [aorc_pkg::TP_W-1:0] TP_LAST = aorc_pkg::TP_W'(aorc_pkg::TP_COUNT - 1);

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			cyc_ff <= '0;
		else if (cyc_ff == CYC_LAST)
			cyc_ff <= '0;
		else
			cyc_ff <= cyc_ff + 7'h01;
	end

	assign minor_tick = (cyc_ff == CYC_LAST);
	// Thirty pulses fit in the first part of the cycle; the tail is idle slack.
	assign tp_tick = (cyc_ff < TP_END) && ((cyc_ff % TP_SP) == 7'h00);

	// The index holds at the last pulse through the slack, so it never names a missing pulse.
	always_ff @(posedge core_clk) begin
		if (!rst_b || minor_tick)
			tp_ff <= '0;
		else if (tp_tick && tp_ff != TP_LAST)
			tp_ff <= tp_ff + 5'h01;
	end

	assign tp_idx = tp_ff;
endmodule // aorc_minor_gen

// ==== verilog/aorc_arith_ctl.sv ====
// Operand buffer, loop register, transfer register, interval timer and dispatcher.
`timescale 1ns/10ps
module aorc_arith_ctl (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic instr_start,
	input wire logic [aorc_pkg::ORDER_W-1:0] order_type,
	input wire logic addr_is_loopreg,
	input wire logic [aorc_pkg::ADDR_W-1:0] addr_field,
	input wire logic [aorc_pkg::TMR_W-1:0] timer_load_val,
	input wire logic [aorc_pkg::OPB_W-1:0] mem_out_word,
	input wire logic [aorc_pkg::WORD_W-1:0] acc_word,
	input wire logic card_mode,
	input wire logic card_strobe,
	input wire logic [aorc_pkg::OPB_W-1:0] card_word,
	input wire logic div_q_bit,
	output logic busy,
	output logic instr_done,
	output logic [aorc_pkg::OPB_W-1:0] operand_word,
	output logic [aorc_pkg::OPB_W-1:0] shift_operand,
	output logic parity_err,
	output logic [aorc_pkg::WORD_W-1:0] loopreg_word,
	output logic [aorc_pkg::OPB_W-1:0] xfer_word,
	output logic [aorc_pkg::TMR_W-1:0] timer_count,
	output logic timer_zero,
	output logic branch_take,
	output logic [aorc_pkg::ADDR_W-1:0] branch_addr,
	output logic timer_to_acc,
	output logic quot_to_acc,
	output logic [aorc_pkg::DATA_W-1:0] quot_word,
	output logic q_lsb_to_acc,
	output logic q_lsb_bit,
	output logic [aorc_pkg::DISP_N-1:0] disp_lines,
	output logic [aorc_pkg::TP_W-1:0] tp_idx
);
	// ----------------------------------------------------------------
	// Timing and decode
	// ----------------------------------------------------------------
	logic minor_tick;
	logic tp_tick;
	aorc_pkg::aorc_state_t state_ff;
	logic [aorc_pkg::ORDER_W-1:0] op_ff;
	logic src_loop_ff;
	logic [aorc_pkg::PASS_W-1:0] pass_ff;
	logic accept;
	logic uses_opnd;
	logic arith_op;
	logic is_div;
	logic loop_src;
	logic line0;
	logic line1;
	logic line2;
	logic done_ff;

	aorc_minor_gen u_minor (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.minor_tick(minor_tick),
		.tp_tick(tp_tick),
		.tp_idx(tp_idx)
	);

	assign accept = instr_start && (state_ff == aorc_pkg::ST_IDLE);

	always_comb begin
		arith_op = 1'b0;
		case (op_ff)
			aorc_pkg::OP_ADD, aorc_pkg::OP_SUB, aorc_pkg::OP_MUL, aorc_pkg::OP_DIV,
			aorc_pkg::OP_MAD, aorc_pkg::OP_SHIFT_LEFT_ADD_LOOPREG_INSTR, aorc_pkg::OP_SHIFT_RIGHT_ADD_LOOPREG_INSTR: arith_op = 1'b1;
			default: arith_op = 1'b0;
		endcase
	end

	assign uses_opnd = arith_op || (op_ff == aorc_pkg::OP_MEM_TEST);
	assign is_div = (op_ff == aorc_pkg::OP_DIV);
	assign loop_src = arith_op && (src_loop_ff || op_ff == aorc_pkg::OP_MAD ||
		op_ff == aorc_pkg::OP_SHIFT_LEFT_ADD_LOOPREG_INSTR || op_ff == aorc_pkg::OP_SHIFT_RIGHT_ADD_LOOPREG_INSTR);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_ff <= aorc_pkg::ST_IDLE;
			op_ff <= aorc_pkg::OP_NOP;
			src_loop_ff <= 1'b0;
			pass_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				aorc_pkg::ST_IDLE: begin
					if (accept) begin
						op_ff <= order_type;
						src_loop_ff <= addr_is_loopreg;
						state_ff <= aorc_pkg::ST_WAIT;
					end
				end
				aorc_pkg::ST_WAIT: begin
					pass_ff <= 5'h01;
					if (minor_tick)
						state_ff <= aorc_pkg::ST_RUN;
				end
				default: begin
					if (minor_tick) begin
						if (is_div && pass_ff != aorc_pkg::DIV_PASSES) begin
							pass_ff <= pass_ff + 5'h01;
						end else begin
							state_ff <= aorc_pkg::ST_IDLE;
							done_ff <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign busy = (state_ff != aorc_pkg::ST_IDLE);
	assign instr_done = done_ff;

	// ----------------------------------------------------------------
	// Dispatcher lines
	// ----------------------------------------------------------------
	logic first_pass;
	assign first_pass = (state_ff == aorc_pkg::ST_RUN) && (pass_ff == 5'h01) && tp_tick;
	assign line2 = first_pass && uses_opnd && (tp_idx == aorc_pkg::TP_CLEAR);
	assign line1 = first_pass && uses_opnd && !loop_src && (tp_idx == aorc_pkg::TP_GATE);
	assign line0 = first_pass && uses_opnd && (tp_idx == aorc_pkg::TP_GATE) &&
		(loop_src || !arith_op);

	always_comb begin
		disp_lines = '0;
		disp_lines[0] = line0;
		disp_lines[1] = line1;
		disp_lines[2] = line2;
	end

	// ----------------------------------------------------------------
	// Operand buffer
	// ----------------------------------------------------------------
	logic [aorc_pkg::OPB_W-1:0] opb_ff;
	logic [aorc_pkg::OPB_W-1:0] loop_in;
	logic par_bad;
	logic err_ff;

	assign loop_in = {~(^loopreg_word) ^ ~aorc_pkg::PAR_ODD, loopreg_word};

	genvar gb;
	generate
		for (gb = 0; gb < aorc_pkg::OPB_W; gb++) begin : g_opb
			always_ff @(posedge core_clk) begin
				if (!rst_b)
					opb_ff[gb] <= aorc_pkg::OPB_RESET[gb];
				else if (line2)
					opb_ff[gb] <= 1'b0;
				else if (line1)
					opb_ff[gb] <= opb_ff[gb] | mem_out_word[gb];
				else if (line0 && loop_src)
					opb_ff[gb] <= opb_ff[gb] | loop_in[gb];
			end
		end
	endgenerate

	assign operand_word = opb_ff;
	assign shift_operand = {opb_ff[aorc_pkg::PAR_BIT:aorc_pkg::DATA_W],
		opb_ff[aorc_pkg::DATA_W-2:0], 1'b0};

	assign par_bad = (^mem_out_word) != aorc_pkg::PAR_ODD;

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			err_ff <= 1'b0;
		else if (line1 && par_bad)
			err_ff <= 1'b1;
		else if (accept)
			err_ff <= 1'b0;
	end

	assign parity_err = err_ff;

	// ----------------------------------------------------------------
	// Loop register
	// ----------------------------------------------------------------
	logic [aorc_pkg::LOOP_SLOTS-1:0] loop_ff;
	logic [aorc_pkg::LOOP_SLOTS-1:0] acc_slots;
	logic div_run;
	assign div_run = (state_ff == aorc_pkg::ST_RUN) && is_div;

	genvar gs;
	generate
		for (gs = 0; gs < aorc_pkg::LOOP_SLOTS; gs++) begin : g_slot
			if ((gs % aorc_pkg::LOOP_N) * aorc_pkg::LOOP_N + gs / aorc_pkg::LOOP_N
				< aorc_pkg::WORD_W) begin : g_used
				assign acc_slots[gs] =
					acc_word[(gs % aorc_pkg::LOOP_N) * aorc_pkg::LOOP_N + gs / aorc_pkg::LOOP_N];
				assign loopreg_word[(gs % aorc_pkg::LOOP_N) * aorc_pkg::LOOP_N +
					gs / aorc_pkg::LOOP_N] = loop_ff[gs];
			end else begin : g_spare
				assign acc_slots[gs] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			loop_ff <= '0;
		else if (accept && order_type == aorc_pkg::OP_LOOP_STORE)
			loop_ff <= acc_slots;
		else if (accept && order_type == aorc_pkg::OP_DIV)
			loop_ff <= '0;
		else if (div_run && minor_tick && pass_ff < aorc_pkg::QLSB_PASS)
			loop_ff <= {loop_ff[aorc_pkg::LOOP_SLOTS-2:0], div_q_bit};
	end

	// ----------------------------------------------------------------
	// Quotient hand-off
	// ----------------------------------------------------------------
	logic qlsb_ff;
	logic qbit_ff;
	logic qacc_ff;
	logic [aorc_pkg::DATA_W-1:0] qword_ff;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			qlsb_ff <= 1'b0;
			qbit_ff <= 1'b0;
			qacc_ff <= 1'b0;
			qword_ff <= '0;
		end else begin
			qlsb_ff <= div_run && minor_tick && pass_ff == aorc_pkg::QLSB_PASS;
			if (div_run && minor_tick && pass_ff == aorc_pkg::QLSB_PASS)
				qbit_ff <= div_q_bit;
			qacc_ff <= div_run && minor_tick && pass_ff == aorc_pkg::DIV_PASSES;
			if (div_run && minor_tick && pass_ff == aorc_pkg::DIV_PASSES)
				qword_ff <= {loop_ff[aorc_pkg::DATA_W-2:0], qbit_ff};
		end
	end

	assign q_lsb_to_acc = qlsb_ff;
	assign q_lsb_bit = qbit_ff;
	assign quot_to_acc = qacc_ff;
	assign quot_word = qword_ff;

	// ----------------------------------------------------------------
	// Transfer register
	// ----------------------------------------------------------------
	logic [aorc_pkg::OPB_W-1:0] xfer_ff;

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			xfer_ff <= '0;
		else if (card_mode && card_strobe)
			xfer_ff <= card_word;
		else if (accept && !card_mode && order_type != aorc_pkg::OP_STORE &&
			order_type != aorc_pkg::OP_MULTIPLEXED_ANALOG_OUTPUT_INSTR)
			xfer_ff <= {~(^acc_word) ^ ~aorc_pkg::PAR_ODD, acc_word};
	end

	assign xfer_word = xfer_ff;

	// ----------------------------------------------------------------
	// Interval timer
	// ----------------------------------------------------------------
	logic [aorc_pkg::TMR_W-1:0] tmr_ff;
	logic tmr_load;
	logic br_ff;
	logic [aorc_pkg::ADDR_W-1:0] br_addr_ff;

	assign tmr_load = accept && order_type == aorc_pkg::OP_LOAD_TMR;

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			tmr_ff <= aorc_pkg::TMR_RESET;
		else if (tmr_load)
			tmr_ff <= timer_load_val;
		else if (minor_tick && tmr_ff != '0)
			tmr_ff <= tmr_ff - 14'h0001;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			br_ff <= 1'b0;
			br_addr_ff <= '0;
		end else begin
			br_ff <= accept && order_type == aorc_pkg::OP_SENSE_TMR && tmr_ff != '0;
			if (accept)
				br_addr_ff <= addr_field;
		end
	end

	assign timer_count = tmr_ff;
	assign timer_zero = (tmr_ff == '0);
	assign branch_take = br_ff;
	assign timer_to_acc = br_ff;
	assign branch_addr = br_addr_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [11:0] run_cyc_ff;
	always_ff @(posedge core_clk) begin
		if (!rst_b || state_ff == aorc_pkg::ST_WAIT)
			run_cyc_ff <= '0;
		else if (state_ff == aorc_pkg::ST_RUN)
			run_cyc_ff <= run_cyc_ff + 12'h001;
	end

	property p_opb_clear;
		@(posedge core_clk) disable iff (!rst_b) line2 |=> operand_word == '0;
	endproperty
	a_opb_clear: assert property (p_opb_clear) else $error("buffer not cleared");
	property p_mem_gate;
		@(posedge core_clk) disable iff (!rst_b)
			line2 ##4 line1 |=> operand_word == $past(mem_out_word);
	endproperty
	a_mem_gate: assert property (p_mem_gate) else $error("memory word not gated");
	property p_par;
		@(posedge core_clk) disable iff (!rst_b) line1 && par_bad |=> parity_err;
	endproperty
	a_par: assert property (p_par) else $error("parity error missed");
	property p_tmr_dec;
		@(posedge core_clk) disable iff (!rst_b)
			minor_tick && !tmr_load && !timer_zero |=> timer_count == $past(timer_count) - 14'h0001;
	endproperty
	a_tmr_dec: assert property (p_tmr_dec) else $error("timer did not step");
	property p_tmr_hold;
		@(posedge core_clk) disable iff (!rst_b) timer_zero && !tmr_load |=> timer_zero;
	endproperty
	a_tmr_hold: assert property (p_tmr_hold) else $error("timer left zero");
	property p_xfer;
		@(posedge core_clk) disable iff (!rst_b)
			accept && !card_mode && order_type == aorc_pkg::OP_ADD
			|=> xfer_word[aorc_pkg::WORD_W-1:0] == $past(acc_word);
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer register stale");
	property p_div_len;
		@(posedge core_clk) disable iff (!rst_b) quot_to_acc |-> run_cyc_ff == 12'ha41;
	endproperty
	a_div_len: assert property (p_div_len) else $error("divide length wrong");
	property p_sense;
		@(posedge core_clk) disable iff (!rst_b)
			accept && order_type == aorc_pkg::OP_SENSE_TMR && !timer_zero
			|=> branch_take && timer_to_acc;
	endproperty
	a_sense: assert property (p_sense) else $error("sense did not branch");
	property p_disp_hi;
		@(posedge core_clk) disable iff (!rst_b) disp_lines[2] |-> !disp_lines[1] && !disp_lines[0];
	endproperty
	a_disp_hi: assert property (p_disp_hi) else $error("clear overlaps gate");
	property p_qlsb;
		@(posedge core_clk) disable iff (!rst_b) q_lsb_to_acc |-> ##125 quot_to_acc;
	endproperty
	a_qlsb: assert property (p_qlsb) else $error("quotient hand-off out of order");

	c_div: cover property (@(posedge core_clk) disable iff (!rst_b) quot_to_acc);
	c_branch: cover property (@(posedge core_clk) disable iff (!rst_b) branch_take);
	c_par: cover property (@(posedge core_clk) disable iff (!rst_b) line1 && par_bad);
	c_loop: cover property (@(posedge core_clk) disable iff (!rst_b) line0 && loop_src);
endmodule // aorc_arith_ctl

// ==== testbench/aorc_far_model.sv ====
// Behavioural model of the memory output register and quotient source facing the block.
`timescale 1ns/10ps
module aorc_far_model (
	core_clk,
	mem_data,
	bad_par,
	q_arm,
	q_pat,
	disp_clear,
	tp_idx,
	mem_out_word,
	div_q_bit
);
	input wire logic core_clk;
	input wire logic [aorc_pkg::WORD_W-1:0] mem_data;
	input wire logic bad_par;
	input wire logic q_arm;
	input wire logic [aorc_pkg::DATA_W-1:0] q_pat;
	input wire logic disp_clear;
	input wire logic [aorc_pkg::TP_W-1:0] tp_idx;
	output logic [aorc_pkg::OPB_W-1:0] mem_out_word;
	output logic div_q_bit;

	int pass_n;
	logic [aorc_pkg::TP_W-1:0] tp_prev_ff;

	// Memory words carry odd parity; bad_par corrupts it on purpose.
	assign mem_out_word = {(~^mem_data) ^ bad_par, mem_data};

	// ----------------------------------------
	// Quotient bits
	// ----------------------------------------
	// The first clear pulse of the divide anchors pass one, since the wait before the run is
	// of unknown length; a bit is presented mid-pass, well before the pass boundary samples it.
	always_ff @(posedge core_clk) begin
		tp_prev_ff <= tp_idx;
		if (!q_arm) begin
			pass_n <= 0;
			div_q_bit <= 1'b0;
		end else if (disp_clear && pass_n == 0) begin
			pass_n <= 1;
		end else if (pass_n > 0 && pass_n <= 20 && tp_idx == 5'h0f && tp_prev_ff != 5'h0f) begin
			div_q_bit <= q_pat[20-pass_n];
			pass_n <= pass_n + 1;
		end
	end
endmodule // aorc_far_model

// ==== testbench/arith_operand_regs_and_control_bench.sv ====
// Self-checking testbench for the operand registers and arithmetic control block.
`timescale 1ns/10ps
module arith_operand_regs_and_control_bench;
	logic core_clk, rst_b, instr_start, addr_is_loopreg, card_mode, card_strobe, div_q_bit;
	logic [aorc_pkg::ORDER_W-1:0] order_type;
	logic [aorc_pkg::ADDR_W-1:0] addr_field, branch_addr;
	logic [aorc_pkg::TMR_W-1:0] timer_load_val, timer_count, tmr_snap, t1;
	logic [aorc_pkg::OPB_W-1:0] mem_out_word, card_word, operand_word, shift_operand, xfer_word;
	logic [aorc_pkg::OPB_W-1:0] xfer_snap;
	logic [aorc_pkg::WORD_W-1:0] acc_word, mem_data, loopreg_word;
	logic [aorc_pkg::DATA_W-1:0] quot_word, q_pat;
	logic [aorc_pkg::DISP_N-1:0] disp_lines, seen;
	logic [aorc_pkg::TP_W-1:0] tp_idx;
	logic busy, instr_done, parity_err, timer_zero, branch_take, timer_to_acc, quot_to_acc;
	logic q_lsb_to_acc, q_lsb_bit, bad_par, q_arm, br;
	int mismatches, tests_run, busy_n, ql, qa, tp_bad;

	aorc_arith_ctl aorc_arith_ctl_inst (.core_clk, .rst_b, .instr_start, .order_type,
		.addr_is_loopreg, .addr_field, .timer_load_val, .mem_out_word, .acc_word, .card_mode,
		.card_strobe, .card_word, .div_q_bit, .busy, .instr_done, .operand_word, .shift_operand,
		.parity_err, .loopreg_word, .xfer_word, .timer_count, .timer_zero, .branch_take,
		.branch_addr, .timer_to_acc, .quot_to_acc, .quot_word, .q_lsb_to_acc, .q_lsb_bit,
		.disp_lines, .tp_idx);

	aorc_far_model aorc_far_model_inst (.core_clk, .mem_data, .bad_par, .q_arm, .q_pat,
		.disp_clear(disp_lines[2]), .tp_idx, .mem_out_word, .div_q_bit);

	function automatic logic [21:0] with_par(input logic [20:0] w);
		return {~^w, w};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Instruction driver
	// ----------------------------------------
	// Snapshots are taken in the cycle after the accepting edge, where one-cycle answers stand.
	task automatic run(input logic [4:0] op, input logic lr, input logic [11:0] adr);
		int n;
		@(negedge core_clk);
		order_type = op;
		addr_is_loopreg = lr;
		addr_field = adr;
		instr_start = 1'b1;
		@(negedge core_clk);
		instr_start = 1'b0;
		xfer_snap = xfer_word;
		tmr_snap = timer_count;
		br = branch_take & timer_to_acc;
		seen = '0;
		busy_n = 0;
		ql = 0;
		qa = 0;
		for (n = 1; n < 3000 && instr_done !== 1'b1; n++) begin
			@(negedge core_clk);
			seen |= disp_lines;
			busy_n += int'(busy);
			br |= branch_take;
			if (q_lsb_to_acc === 1'b1) ql = n;
			if (quot_to_acc === 1'b1) qa = n;
			if (tp_idx > 5'h1d) tp_bad++;
		end
		if (n >= 3000) mismatches++;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		check(busy, 1'b0);
		check(timer_zero, 1'b1);
		check(xfer_word, 22'h000000);
		$display("test reset state done");
	endtask

	task automatic t_mem_operand;
		acc_word = 21'h12a5f;
		mem_data = 21'h0f00d;
		run(aorc_pkg::OP_ADD, 1'b0, 12'h000);
		check(xfer_snap, with_par(21'h12a5f));
		check(operand_word, with_par(21'h0f00d));
		check(parity_err, 1'b0);
		check(seen[2:0], 3'h6);
		check(seen[9:3], 7'h00);
		check(shift_operand, 22'h01e01a);
		bad_par = 1'b1;
		run(aorc_pkg::OP_SUB, 1'b0, 12'h000);
		check(parity_err, 1'b1);
		bad_par = 1'b0;
		run(aorc_pkg::OP_MEM_TEST, 1'b0, 12'h000);
		check(seen[1:0], 2'h3);
		check(parity_err, 1'b0);
		run(aorc_pkg::OP_MUL, 1'b0, 12'h000);
		check(operand_word, with_par(21'h0f00d));
		check(seen[2:0], 3'h6);
		$display("test memory operand done");
	endtask

	task automatic t_store_lag;
		acc_word = 21'h0abcd;
		run(aorc_pkg::OP_NOP, 1'b0, 12'h000);
		acc_word = 21'h15555;
		run(aorc_pkg::OP_STORE, 1'b0, 12'h000);
		check(xfer_word, with_par(21'h0abcd));
		run(aorc_pkg::OP_MULTIPLEXED_ANALOG_OUTPUT_INSTR, 1'b0, 12'h000);
		check(xfer_word, with_par(21'h0abcd));
		$display("test transfer lag done");
	endtask

	task automatic t_loopreg;
		acc_word = 21'h1c3a7;
		run(aorc_pkg::OP_LOOP_STORE, 1'b0, 12'h000);
		check(loopreg_word, 21'h1c3a7);
		mem_data = 21'h00001;
		run(aorc_pkg::OP_MAD, 1'b0, 12'h000);
		check(operand_word[20:0], 21'h1c3a7);
		check(seen[2:0], 3'h5);
		run(aorc_pkg::OP_ADD, 1'b1, 12'h000);
		check(operand_word[20:0], 21'h1c3a7);
		run(aorc_pkg::OP_SHIFT_LEFT_ADD_LOOPREG_INSTR, 1'b0, 12'h000);
		check(seen[2:0], 3'h5);
		run(aorc_pkg::OP_SHIFT_RIGHT_ADD_LOOPREG_INSTR, 1'b0, 12'h000);
		check(operand_word, with_par(21'h1c3a7));
		$display("test loop register done");
	endtask

	task automatic t_timer;
		int k;
		timer_load_val = 14'h3fff;
		run(aorc_pkg::OP_LOAD_TMR, 1'b0, 12'h000);
		check(tmr_snap, 14'h3fff);
		t1 = timer_count;
		repeat (aorc_pkg::MINOR_CYC) @(negedge core_clk);
		check(timer_count, t1 - 14'h0001);
		run(aorc_pkg::OP_SENSE_TMR, 1'b0, 12'h5a6);
		check(br, 1'b1);
		check(branch_addr, 12'h5a6);
		timer_load_val = 14'h0003;
		run(aorc_pkg::OP_LOAD_TMR, 1'b0, 12'h000);
		for (k = 0; k < 10; k++) begin
			run(aorc_pkg::OP_SENSE_TMR, 1'b0, 12'h040);
			if (br !== 1'b1) break;
		end
		check(k > 0 && k < 10, 1'b1);
		check(timer_count, 14'h0000);
		repeat (300) @(negedge core_clk);
		check(timer_zero, 1'b1);
		$display("test interval timer done");
	endtask

	task automatic t_card;
		card_mode = 1'b1;
		card_word = 22'h2d1e0f;
		card_strobe = 1'b1;
		@(negedge core_clk);
		card_strobe = 1'b0;
		check(xfer_word, 22'h2d1e0f);
		card_mode = 1'b0;
		$display("test card path done");
	endtask

	task automatic t_divide;
		q_pat = 20'ha5c3b;
		q_arm = 1'b1;
		run(aorc_pkg::OP_DIV, 1'b0, 12'h000);
		q_arm = 1'b0;
		check(quot_word, 20'ha5c3b);
		check(q_lsb_bit, 1'b1);
		check(operand_word, with_par(21'h00001));
		check(qa - ql, 125);
		check(busy_n >= 2625 && busy_n <= 2751, 1'b1);
		check(tp_bad, 0);
		$display("test divide done");
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		#(20000 * 40);
		mismatches++;
		print_verdict();
	end

	initial begin
		{rst_b, instr_start, addr_is_loopreg, card_mode, card_strobe, bad_par, q_arm} = '0;
		{order_type, addr_field, timer_load_val, card_word, acc_word, mem_data, q_pat} = '0;
		{mismatches, tests_run, tp_bad} = '0;
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		t_reset();
		t_mem_operand();
		t_store_lag();
		t_loopreg();
		t_timer();
		t_card();
		t_divide();
		print_verdict();
	end
endmodule // arith_operand_regs_and_control_bench
